/* core/udr_pkg.sv */
// Constants and types for the descriptor responder.
// Shared by the responder core and its bench.
package udr_pkg;
  // Descriptor type codes
  localparam logic [7:0] DT_QUAL = 8'h06;
  localparam logic [7:0] DT_STRING = 8'h03;
  localparam logic [7:0] DT_COMP = 8'h30;
  // Device qualifier
  localparam logic [7:0] QUAL_LEN = 8'h0A;
  localparam logic [7:0] QUAL_RSVD = 8'h00;
  localparam logic [15:0] QUAL_BCD_DEF = 16'h0210;
  localparam logic [7:0] QUAL_CLASS_DEF = 8'hFF;
  localparam logic [7:0] QUAL_SUB_DEF = 8'h00;
  localparam logic [7:0] QUAL_PROTO_DEF = 8'hFF;
  localparam logic [7:0] QUAL_MPS_DEF = 8'h40;
  localparam logic [7:0] QUAL_NCFG_DEF = 8'h01;
  // Loadable fields, byte 0 at bits 7:0: bcd lo, bcd hi, class, sub,
  // protocol, max packet, configuration count
  localparam logic [55:0] QUAL_FIELD_DEF = {QUAL_NCFG_DEF, QUAL_MPS_DEF,
    QUAL_PROTO_DEF, QUAL_SUB_DEF, QUAL_CLASS_DEF, QUAL_BCD_DEF[15:8],
    QUAL_BCD_DEF[7:0]};
  // Language string
  localparam logic [7:0] LANG_LEN = 8'h04;
  localparam logic [8:0] LANG_ADDR_LO = 9'h023;
  localparam logic [8:0] LANG_ADDR_HI = 9'h024;
  // Bulk-in endpoint companion
  localparam logic [7:0] COMP_LEN = 8'h06;
  localparam logic [7:0] COMP_ATTR = 8'h00;
  localparam logic [15:0] COMP_BPI = 16'h0000;
  localparam logic [3:0] COMP_BURST_DEF = 4'h3;
  // Indexed strings
  localparam int STR_COUNT = 5;
  // Descriptor kinds
  localparam logic [1:0] K_QUAL = 2'h0;
  localparam logic [1:0] K_LANG = 2'h1;
  localparam logic [1:0] K_STR = 2'h2;
  localparam logic [1:0] K_COMP = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_WAIT, ST_SHOW} udr_state_t;
endpackage : udr_pkg

/* core/udr_responder.sv */
// Descriptor responder: qualifier, string and bulk-in companion bytes.
// Assumes the control engine hands over one decoded request at a time
// and that the store image answers reads in the same cycle.
//
// Operation
// - A qualifier request is stalled while running SuperSpeed.
// - The qualifier is ten bytes with fixed length, type and last byte.
// - Version, class, subclass and protocol come from the store or defaults.
// - Max packet and configuration count are loaded and must match defaults; nothing checks this, they are sent as loaded.
// - Qualifier fields are taken from the opposite high or full speed set.
// - String zero is four bytes, length 04h, type 03h, then the language.
// - String zero stalls with no valid store or all string lengths zero.
// - String zero returns the store bytes at 0x23-0x24 as the language.
// - The language code in a string request is ignored.
// - Strings 1-5 stall with no valid store, zero length or zero offset.
// - An existing string is sent byte for byte from its store area.
// - The companion is six bytes, length 06h, type 30h, never from store.
// - The companion burst byte mirrors the configured bulk-in burst limit.
// - The companion attributes are 00h and bytes per interval 0000h.
`timescale 1ns/100ps
module udr_responder
  import udr_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Decoded request
  input wire logic req,
  input wire logic [7:0] req_type,
  input wire logic [7:0] req_index,
  input wire logic [15:0] req_langid,
  input wire logic [15:0] req_length,
  // Link state and configuration
  input wire logic speed_ss,
  input wire logic speed_hs,
  input wire logic [3:0] bulk_in_burst_limit,
  // Store contents
  input wire logic store_ok,
  input wire logic dev_loaded,
  input wire logic [55:0] hs_dev_fields,
  input wire logic [55:0] fs_dev_fields,
  input wire logic [39:0] str_len_flat,
  input wire logic [39:0] str_off_flat,
  output logic store_rd,
  output logic [8:0] store_addr,
  input wire logic [7:0] store_rdata,
  // Data stage
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  output logic stall,
  output logic done,
  output logic busy
);
  typedef struct packed {
    udr_state_t st;
    logic [1:0] kind;
    logic [7:0] base;
    logic [15:0] left;
    logic [7:0] pos;
    logic [7:0] data;
    logic tx_valid;
    logic tx_last;
    logic stall;
    logic done;
    logic busy;
    logic rd;
    logic [8:0] addr;
  } udr_reg_t;

  udr_reg_t r;
  udr_reg_t next_r;
  logic [55:0] qual_fields;
  logic [2:0] str_sel;
  logic [7:0] str_len;
  logic [7:0] str_off;

  // Bytes not taken from the store
  function automatic logic [7:0] fixed_byte(input logic [1:0] k,
      input logic [7:0] p, input logic [55:0] f, input logic [3:0] burst);
    int j;
    j = 0;
    fixed_byte = 8'h00;
    case (k)
      K_QUAL: begin
        if (p == 8'h00) fixed_byte = QUAL_LEN;
        else if (p == 8'h01) fixed_byte = DT_QUAL;
        else if (p < 8'h09) begin
          j = int'(p) - 2;
          fixed_byte = f[j*8 +: 8];
        end else fixed_byte = QUAL_RSVD;
      end
      K_LANG: begin
        if (p == 8'h00) fixed_byte = LANG_LEN;
        else fixed_byte = DT_STRING;
      end
      K_COMP: begin
        case (p)
          8'h00: fixed_byte = COMP_LEN;
          8'h01: fixed_byte = DT_COMP;
          8'h02: fixed_byte = {4'h0, burst};
          8'h03: fixed_byte = COMP_ATTR;
          8'h04: fixed_byte = COMP_BPI[7:0];
          default: fixed_byte = COMP_BPI[15:8];
        endcase
      end
      default: fixed_byte = 8'h00;
    endcase
  endfunction : fixed_byte

  // Opposite speed set, or defaults when nothing is loaded
  assign qual_fields = !dev_loaded ? QUAL_FIELD_DEF :
    (speed_hs ? fs_dev_fields : hs_dev_fields);
  assign str_sel = req_index[2:0] - 3'h1;
  assign str_len = str_len_flat[8*str_sel +: 8];
  assign str_off = str_off_flat[8*str_sel +: 8];

  always_comb begin
    logic [7:0] dlen;
    logic start;
    dlen = 8'h00;
    start = 1'b0;
    next_r = r;
    next_r.stall = 1'b0;
    next_r.done = 1'b0;
    next_r.rd = 1'b0;
    case (r.st)
      ST_IDLE: begin
        // The language code of a request is never looked at
        if (req) begin
          if (req_type == DT_QUAL) begin
            if (speed_ss) next_r.stall = 1'b1;
            else begin
              start = 1'b1;
              next_r.kind = K_QUAL;
              dlen = QUAL_LEN;
            end
          end else if (req_type == DT_STRING && req_index == 8'h00) begin
            if (!store_ok || str_len_flat == 40'h0) next_r.stall = 1'b1;
            else begin
              start = 1'b1;
              next_r.kind = K_LANG;
              dlen = LANG_LEN;
            end
          end else if (req_type == DT_STRING &&
                       req_index <= 8'(STR_COUNT)) begin
            if (!store_ok || str_len == 8'h00 || str_off == 8'h00)
              next_r.stall = 1'b1;
            else begin
              start = 1'b1;
              next_r.kind = K_STR;
              next_r.base = str_off;
              dlen = str_len;
            end
          end else if (req_type == DT_COMP) begin
            start = 1'b1;
            next_r.kind = K_COMP;
            dlen = COMP_LEN;
          end else next_r.stall = 1'b1;
          if (start) begin
            next_r.pos = 8'h00;
            next_r.left = (req_length < {8'h00, dlen}) ? req_length :
              {8'h00, dlen};
            if (next_r.left == 16'h0000) next_r.done = 1'b1;
            else begin
              next_r.st = ST_PREP;
              next_r.busy = 1'b1;
            end
          end
        end
      end
      ST_PREP: begin
        if (r.kind == K_STR) begin
          next_r.rd = 1'b1;
          next_r.addr = {1'b0, r.base} + {1'b0, r.pos};
          next_r.st = ST_WAIT;
        end else if (r.kind == K_LANG && r.pos >= 8'h02) begin
          next_r.rd = 1'b1;
          next_r.addr = (r.pos == 8'h02) ? LANG_ADDR_LO : LANG_ADDR_HI;
          next_r.st = ST_WAIT;
        end else begin
          next_r.data = fixed_byte(r.kind, r.pos, qual_fields,
            bulk_in_burst_limit);
          next_r.tx_valid = 1'b1;
          next_r.tx_last = (r.left == 16'h0001);
          next_r.st = ST_SHOW;
        end
      end
      ST_WAIT: begin
        next_r.data = store_rdata;
        next_r.tx_valid = 1'b1;
        next_r.tx_last = (r.left == 16'h0001);
        next_r.st = ST_SHOW;
      end
      ST_SHOW: begin
        if (tx_ready) begin
          next_r.tx_valid = 1'b0;
          next_r.tx_last = 1'b0;
          next_r.left = r.left - 16'h0001;
          next_r.pos = r.pos + 8'h01;
          if (r.left == 16'h0001) begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
            next_r.st = ST_IDLE;
          end else next_r.st = ST_PREP;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) r <= '0;
    else if (ce) r <= next_r;
  end

  assign tx_data = r.data;
  assign tx_valid = r.tx_valid;
  assign tx_last = r.tx_last;
  assign stall = r.stall;
  assign done = r.done;
  assign busy = r.busy;
  assign store_rd = r.rd;
  assign store_addr = r.addr;
  // Checks
  logic [15:0] sent_q;
  logic [15:0] lim_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sent_q <= 16'h0000;
      lim_q <= 16'h0000;
    end else if (ce) begin
      if (r.st == ST_IDLE && req) begin
        sent_q <= 16'h0000;
        lim_q <= req_length;
      end else if (r.tx_valid && tx_ready) sent_q <= sent_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_qual_ss_stall: assert property (
    (ce && r.st == ST_IDLE && req && req_type == DT_QUAL && speed_ss)
      |=> (stall && !busy))
    else $error("qualifier not stalled in superspeed");
  a_qual_fixed: assert property (
    (tx_valid && r.kind == K_QUAL) |->
      ((r.pos == 8'h00) ? tx_data == 8'h0A :
       (r.pos == 8'h01) ? tx_data == 8'h06 :
       (r.pos == 8'h09) ? tx_data == 8'h00 : 1'b1))
    else $error("qualifier fixed byte wrong");
  a_qual_speed: assert property (
    (tx_valid && r.kind == K_QUAL && r.pos == 8'h04 && dev_loaded &&
     $stable(speed_hs)) |->
      tx_data == (speed_hs ? fs_dev_fields[23:16] : hs_dev_fields[23:16]))
    else $error("qualifier class not from opposite speed");
  a_qual_default: assert property (
    (tx_valid && r.kind == K_QUAL && r.pos == 8'h02 && !dev_loaded &&
     $stable(dev_loaded)) |-> tx_data == 8'h10)
    else $error("qualifier version default wrong");
  a_lang_stall: assert property (
    (ce && r.st == ST_IDLE && req && req_type == DT_STRING &&
     req_index == 8'h00 && !store_ok) |=> stall)
    else $error("language string not stalled");
  a_lang_addr: assert property (
    (store_rd && r.kind == K_LANG) |->
      (store_addr == 9'h023 || store_addr == 9'h024))
    else $error("language read from wrong address");
  a_str_stall: assert property (
    (ce && r.st == ST_IDLE && req && req_type == DT_STRING &&
     req_index != 8'h00 && req_index < 8'h06 && !store_ok) |=> stall)
    else $error("string without store not stalled");
  a_str_passthru: assert property (
    (ce && r.st == ST_WAIT) |=> (tx_valid && tx_data == $past(store_rdata)))
    else $error("store byte altered");
  a_comp_bytes: assert property (
    (tx_valid && r.kind == K_COMP && r.pos < 8'h02) |->
      tx_data == ((r.pos == 8'h00) ? 8'h06 : 8'h30))
    else $error("companion header wrong");
  a_comp_burst: assert property (
    (tx_valid && r.kind == K_COMP && r.pos == 8'h02 &&
     $stable(bulk_in_burst_limit)) |-> tx_data == {4'h0, bulk_in_burst_limit})
    else $error("companion burst wrong");
  a_comp_zero: assert property (
    (tx_valid && r.kind == K_COMP && r.pos > 8'h02) |-> tx_data == 8'h00)
    else $error("companion attribute or interval not zero");
  a_len_bound: assert property (
    (tx_valid) |-> (sent_q < lim_q && sent_q < 16'h0100))
    else $error("more bytes than requested");

  c_qual_sent: cover property (done && r.kind == K_QUAL);
  c_str_sent: cover property (done && r.kind == K_STR);
  c_comp_sent: cover property (done && r.kind == K_COMP);
  c_stall_seen: cover property (stall);
endmodule : udr_responder

/* dv/udr_store_model.sv */
// Store image model answering reads in the same cycle.
// Assumes the responder pulses store_rd with a valid address.
`timescale 1ns/100ps
module udr_store_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic store_rd,
  input wire logic [8:0] store_addr,
  output logic [7:0] store_rdata
);
  logic [7:0] pat = 8'h00;
  function automatic logic [7:0] img(input logic [8:0] a);
    if (a == 9'h023) return 8'h09;
    if (a == 9'h024) return 8'h04;
    // String k+1 heads 40h+10h*k, header matching its 2k+2 bytes
    if (a[8:4] >= 5'h04 && a[8:4] <= 5'h08 && a[3:1] == 3'h0)
      return a[0] ? 8'h03 : 8'(2 * int'(a[8:4]) - 6);
    return a[7:0] ^ {7'h0, a[8]} ^ 8'hA5;
  endfunction : img
  always @(posedge clk) pat <= pat + 8'h3B;
  // Idle reads show a shifting pattern
  assign store_rdata = store_rd ? img(store_addr) : pat;
endmodule : udr_store_model

/* dv/usb_descriptor_responder_tb.sv */
// Random and corner requests against the descriptor responder.
// Assumes the store model answers reads combinationally.
`timescale 1ns/100ps
module usb_descriptor_responder_tb;
  import udr_pkg::*;
  logic clk = 0, rst = 1, ce = 1, req = 0, speed_ss = 0, speed_hs = 0;
  logic store_ok = 0, dev_loaded = 0, tx_ready = 0;
  logic [7:0] req_type = 8'h00, req_index = 8'h00;
  logic [15:0] req_langid = 16'h0000, req_length = 16'h0000;
  logic [3:0] bulk_in_burst_limit = 4'h3;
  logic [55:0] hs_dev_fields = '0, fs_dev_fields = '0;
  logic [39:0] str_len_flat = '0, str_off_flat = '0;
  logic store_rd, tx_valid, tx_last, stall, done, busy;
  logic [8:0] store_addr;
  logic [7:0] store_rdata, tx_data;
  logic [7:0] types [5] = '{DT_QUAL, DT_STRING, DT_STRING, DT_COMP, 8'h01};
  int mismatches = 0, n_checks = 0, cyc = 0;
  udr_responder udr_responder_i (.clk, .rst, .ce, .req, .req_type,
    .req_index, .req_langid, .req_length, .speed_ss, .speed_hs,
    .bulk_in_burst_limit, .store_ok, .dev_loaded, .hs_dev_fields,
    .fs_dev_fields, .str_len_flat, .str_off_flat, .store_rd, .store_addr,
    .store_rdata, .tx_data, .tx_valid, .tx_last, .tx_ready, .stall,
    .done, .busy);
  udr_store_model udr_store_model_i (.clk, .store_rd, .store_addr,
    .store_rdata);
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] img(input logic [8:0] a);
    if (a == 9'h023) return 8'h09;
    if (a == 9'h024) return 8'h04;
    if (a[8:4] >= 5'h04 && a[8:4] <= 5'h08 && a[3:1] == 3'h0)
      return a[0] ? DT_STRING : 8'(2 * int'(a[8:4]) - 6);
    return a[7:0] ^ {7'h0, a[8]} ^ 8'hA5;
  endfunction : img
  function automatic logic [7:0] nth(input logic [39:0] v, input int k);
    return v[8*k +: 8];
  endfunction : nth
  // Descriptor length, zero where a stall is due
  function automatic int dlen();
    int k;
    k = req_index - 1;
    case (req_type)
      DT_QUAL: return speed_ss ? 0 : 10;
      DT_COMP: return 6;
      DT_STRING:
        if (!store_ok) return 0;
        else if (req_index == 0) return (str_len_flat != 0) ? 4 : 0;
        else if (req_index > 5) return 0;
        else if (nth(str_len_flat, k) == 0) return 0;
        else if (nth(str_off_flat, k) == 0) return 0;
        else return nth(str_len_flat, k);
      default: return 0;
    endcase
  endfunction : dlen
  function automatic logic [7:0] eb(input int i);
    logic [55:0] f;
    f = !dev_loaded ? QUAL_FIELD_DEF : speed_hs ? fs_dev_fields
      : hs_dev_fields;
    if (req_type == DT_QUAL)
      return i == 0 ? QUAL_LEN : i == 1 ? DT_QUAL : i == 9 ? QUAL_RSVD
        : f[8*(i-2) +: 8];
    if (req_type == DT_COMP)
      return i == 0 ? COMP_LEN : i == 1 ? DT_COMP : i == 2
        ? {4'h0, bulk_in_burst_limit} : i == 3 ? COMP_ATTR
        : COMP_BPI[8*(i-4) +: 8];
    if (req_index == 0)
      return i == 0 ? LANG_LEN : i == 1 ? DT_STRING
        : img(LANG_ADDR_LO + 9'(i - 2));
    return img({1'b0, nth(str_off_flat, req_index - 1)} + 9'(i));
  endfunction : eb
  task automatic run();
    int n, m, t;
    logic [7:0] got [$];
    logic st, dn;
    n = dlen();
    m = n < req_length ? n : req_length;
    st = 0;
    dn = 0;
    chk(busy, 0);
    req = 1;
    for (t = 0; t < 300 && !st && !dn; t++) begin
      @(negedge clk);
      st = stall;
      dn = done;
      // Hold the request until taken; while busy it must be ignored
      req = (st | dn) ? 1'b0 : busy ? 1'($urandom) : 1'b1;
      // Run on at the end so a stall or done pulse clears
      ce = (st | dn) ? 1'b1 : ($urandom % 8) != 0;
      tx_ready = ($urandom % 3) != 0;
      if (tx_valid && tx_ready && ce) begin
        got.push_back(tx_data);
        chk(tx_last, got.size() == m);
      end
    end
    chk(st, n == 0);
    chk(dn, n != 0);
    chk(got.size(), m);
    for (int i = 0; i < got.size(); i++)
      chk(got[i], eb(i));
  endtask : run
  initial begin
    int c;
    void'($urandom(51));
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    chk({busy, tx_valid, stall, done, store_rd}, 0);
    for (int it = 0; it < 90; it++) begin
      @(negedge clk);
      if (it < 5) begin
        case (it)
          0: req_type = DT_COMP;
          1: begin
            req_length = 16'h0006;
            bulk_in_burst_limit = 4'hF;
          end
          2: begin
            req_type = DT_QUAL;
            speed_ss = 1;
          end
          3: begin
            req_type = DT_STRING;
            store_ok = 1;
            req_length = 16'h00FF;
          end
          default: begin
            req_type = DT_QUAL;
            speed_ss = 0;
          end
        endcase
      end else begin
        {speed_ss, speed_hs, store_ok, dev_loaded} = 4'($urandom);
        bulk_in_burst_limit = 4'($urandom);
        hs_dev_fields = 56'({$urandom, $urandom});
        fs_dev_fields = 56'({$urandom, $urandom});
        for (int k = 0; k < 5; k++) begin
          c = $urandom % 4;
          str_len_flat[8*k +: 8] = (c == 0) ? 8'h00 : 8'(2 * k + 2);
          str_off_flat[8*k +: 8] = (c == 1) ? 8'h00 : 8'(8'h40 + 16 * k);
        end
        req_langid = 16'($urandom);
        req_length = 16'($urandom % 12 + 1);
        req_type = types[$urandom % 5];
        req_index = 8'($urandom % 8);
      end
      run();
    end
    close_out();
  end
endmodule : usb_descriptor_responder_tb
